// ---- evmask_pkg.sv ----
// package for the event flag and mask bank
// assumes a byte-wide register port and a single 100 MHz clock
package evmask_pkg;

  // register indices on the control port
  localparam logic [7:0] FIRST_FLAGS_ADDR = 8'h39;
  localparam logic [7:0] FIRST_MASK_ADDR  = 8'h3a;
  localparam logic [7:0] PIN_FLAGS_ADDR   = 8'h3b;
  localparam logic [7:0] PIN_MASK_ADDR    = 8'h3c;

  // reset values
  localparam logic [7:0] FLAGS_RESET      = 8'h00;
  localparam logic [7:0] MASK_FALLBACK    = 8'hff;
  localparam logic [7:0] RDATA_RESET      = 8'h00;

  // first-group field positions
  localparam int HOLD_FALL_BIT   = 0;
  localparam int SUPPLY_MON_BIT  = 1;
  localparam int BUTTON_BIT      = 2;
  localparam int BUTTON_LONG_BIT = 3;
  localparam int HOLD_RISE_BIT   = 4;
  localparam int OVERTEMP_BIT    = 5;
  localparam int PIN1_RISE_BIT   = 6;
  localparam int PIN1_FALL_BIT   = 7;

  // pin-edge layout: pin n (2..5) rise at bit 2*(n-2), fall one above
  localparam int EDGE_PINS = 4;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

endpackage : evmask_pkg

// ---- event_flag_mask_bank.sv ----
// event flag and mask bank: two sticky flag registers, two mask registers,
// one level interrupt output.
// assumes event inputs are one-cycle pulses synchronous to CLK_IN and that
// pin levels are already synchronised; mask defaults arrive from the
// nonvolatile configuration on static inputs.
//
// Behaviour
// - first-group mask at 3Ah, eight event masks
// - mask zero passes event, one blocks it
// - reset loads factory masks a cycle after release, clears all flags
// - pin-edge flags at 3Bh, pins two to five
// - edge flag sets on edge, holds till cleared
// - write one clears flag, zero leaves it
// - all pin-edge flags zero after reset
// - pin-edge mask at 3Ch, same layout
// - first-group flags at 39h, write-one clear
`timescale 1ns/1ps
module event_flag_mask_bank (
  // clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  // factory mask defaults
  input  wire logic [7:0] FIRST_MASK_DEFAULT_IN,
  input  wire logic [7:0] PIN_MASK_DEFAULT_IN,
  // first-group event pulses, laid out as the flag register
  input  wire logic [7:0] FIRST_EVENT_IN,
  // pin levels of pins two to five, bit 0 is pin two
  input  wire logic [3:0] PIN_LEVEL_IN,
  // register port
  input  wire logic [7:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  // interrupt
  output logic            IRQ_OUT
);

  evmask_pkg::reg_req_s req;
  logic [7:0] first_flags_q;
  logic [7:0] first_mask_q;
  logic [7:0] pin_flags_q;
  logic [7:0] pin_mask_q;
  logic [3:0] pin_prev_q;
  logic       seeded_q;
  logic [7:0] pin_edge;
  logic [7:0] rdata_d;

  assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // previous pin levels; first cycle after reset only seeds them
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pin_prev_q <= 4'h0;
      seeded_q   <= 1'b0;
    end else begin
      pin_prev_q <= PIN_LEVEL_IN;
      seeded_q   <= 1'b1;
    end
  end

  // per pin: rise at even bit, fall at odd bit
  genvar g;
  generate
    for (g = 0; g < evmask_pkg::EDGE_PINS; g++) begin : g_edge
      assign pin_edge[2*g]   = seeded_q & PIN_LEVEL_IN[g] & ~pin_prev_q[g];
      assign pin_edge[2*g+1] = seeded_q & ~PIN_LEVEL_IN[g] & pin_prev_q[g];
    end
  endgenerate

  // first-group sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      first_flags_q <= evmask_pkg::FLAGS_RESET;
    end else begin
      first_flags_q <= (first_flags_q
                        & ~((req.wr && req.addr == evmask_pkg::FIRST_FLAGS_ADDR)
                            ? req.wdata : 8'h00))
                       | FIRST_EVENT_IN;
    end
  end

  // pin-edge sticky flags, captured whatever the mask says
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pin_flags_q <= evmask_pkg::FLAGS_RESET;
    end else begin
      pin_flags_q <= (pin_flags_q
                      & ~((req.wr && req.addr == evmask_pkg::PIN_FLAGS_ADDR)
                          ? req.wdata : 8'h00))
                     | pin_edge;
    end
  end

  // reset value must be a constant, so defaults are loaded on the
  // first cycle after release; masks stay all-blocking until then
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      first_mask_q <= evmask_pkg::MASK_FALLBACK;
      pin_mask_q   <= evmask_pkg::MASK_FALLBACK;
    end else if (!seeded_q) begin
      first_mask_q <= FIRST_MASK_DEFAULT_IN;
      pin_mask_q   <= PIN_MASK_DEFAULT_IN;
    end else if (req.wr) begin
      if (req.addr == evmask_pkg::FIRST_MASK_ADDR) begin
        first_mask_q <= req.wdata;
      end
      if (req.addr == evmask_pkg::PIN_MASK_ADDR) begin
        pin_mask_q <= req.wdata;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    case (req.addr)
      evmask_pkg::FIRST_FLAGS_ADDR: rdata_d = first_flags_q;
      evmask_pkg::FIRST_MASK_ADDR:  rdata_d = first_mask_q;
      evmask_pkg::PIN_FLAGS_ADDR:   rdata_d = pin_flags_q;
      evmask_pkg::PIN_MASK_ADDR:    rdata_d = pin_mask_q;
      default:                      rdata_d = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= evmask_pkg::RDATA_RESET;
    end else begin
      RDATA_OUT <= req.rd ? rdata_d : 8'h00;
    end
  end

  // registered level interrupt, one cycle behind the flags
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(first_flags_q & ~first_mask_q)
               | |(pin_flags_q & ~pin_mask_q);
    end
  end

endmodule : event_flag_mask_bank

// ---- evmask_checker.sv ----
// port checker for the event flag and mask bank
// assumes bind to the top module, one clock, sync reset
`timescale 1ns/1ps
module evmask_checker (
  input wire logic       CLK_IN,
  input wire logic       RST_IN,
  input wire logic [7:0] FIRST_EVENT_IN,
  input wire logic [3:0] PIN_LEVEL_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic       WR_IN,
  input wire logic       RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic       IRQ_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // read data only in the cycle after a read
  rdata_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00) else $error("rdata idle");
  unmapped_read_a: assert property ($past(RD_IN) && !($past(ADDR_IN) inside {[8'h39:8'h3c]})
    |-> RDATA_OUT == 8'h00) else $error("unmapped read");
  // write then read back; the write at release is lost to the default load
  pin_mask_a: assert property ($past(WR_IN,2) && $past(ADDR_IN,2) == 8'h3c && $past(RD_IN) &&
    $past(ADDR_IN) == 8'h3c && !$past(RST_IN,3) |-> RDATA_OUT == $past(WDATA_IN,2))
    else $error("pin mask readback");
  first_mask_a: assert property ($past(WR_IN,2) && $past(ADDR_IN,2) == 8'h3a && $past(RD_IN) &&
    $past(ADDR_IN) == 8'h3a && !$past(RST_IN,3) |-> RDATA_OUT == $past(WDATA_IN,2))
    else $error("first mask readback");
  // written ones clear unless a pin moved at that edge
  w1c_clear_a: assert property ($past(WR_IN,2) && $past(ADDR_IN,2) == 8'h3b && $past(RD_IN) &&
    $past(ADDR_IN) == 8'h3b && $past(PIN_LEVEL_IN,2) == $past(PIN_LEVEL_IN,3)
    |-> (RDATA_OUT & $past(WDATA_IN,2)) == 8'h00) else $error("w1c clear");
  first_capture_a: assert property ($past(RD_IN) && $past(ADDR_IN) == 8'h39 &&
    !$past(RST_IN,2) |-> (RDATA_OUT & $past(FIRST_EVENT_IN,2)) == $past(FIRST_EVENT_IN,2))
    else $error("first capture");
  pin_capture_a: assert property ($past(RD_IN) && $past(ADDR_IN) == 8'h3b &&
    $past(PIN_LEVEL_IN[0],2) && !$past(PIN_LEVEL_IN[0],3) && !$past(RST_IN,3)
    |-> RDATA_OUT[0]) else $error("pin capture");
  irq_reset_a: assert property ($fell(RST_IN) |-> !IRQ_OUT ##1 !IRQ_OUT)
    else $error("irq after reset");
endmodule : evmask_checker

bind event_flag_mask_bank evmask_checker chk_i (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .FIRST_EVENT_IN(FIRST_EVENT_IN), .PIN_LEVEL_IN(PIN_LEVEL_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT));

// ---- event_flag_mask_bank_tb.sv ----
// testbench for the event flag and mask bank
// assumes the bound checker; tasks start just after a clock edge
`timescale 1ns/1ps
module event_flag_mask_bank_tb;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq;
  logic [7:0] ev = 8'h00, addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0] pins = 4'h0;
  int         fails = 0, num_checks = 0;
  always #5 clk = ~clk;
  event_flag_mask_bank dut (.CLK_IN(clk), .RST_IN(rst), .FIRST_MASK_DEFAULT_IN(8'h5a),
    .PIN_MASK_DEFAULT_IN(8'ha5), .FIRST_EVENT_IN(ev), .PIN_LEVEL_IN(pins), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle strobes, so a read may follow a write with no gap
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    rd <= 1'b1; addr <= a;
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_reg
  task automatic t_reset;
    rd_reg(8'h3a, 8'h5a);
    rd_reg(8'h3c, 8'ha5);
    rd_reg(8'h3b, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask : t_reset
  task automatic t_pins;
    wr_reg(8'h3c, 8'hff);
    pins <= 4'hf;
    @(posedge clk);
    rd_reg(8'h3b, 8'h55);
    pins <= 4'h0;
    @(posedge clk);
    rd_reg(8'h3b, 8'hff);
    chk({7'h00, irq}, 8'h00);
    wr_reg(8'h3b, 8'h01);
    rd_reg(8'h3b, 8'hfe);
    wr_reg(8'h3c, 8'hfd);
    rd_reg(8'h3c, 8'hfd);
    @(posedge clk) #1 chk({7'h00, irq}, 8'h01);
    wr_reg(8'h3b, 8'h02);
    @(posedge clk) #1 chk({7'h00, irq}, 8'h00);
    rd_reg(8'h3d, 8'h00);
  endtask : t_pins
  task automatic t_first;
    wr_reg(8'h3a, 8'hff);
    ev <= 8'h81;
    @(posedge clk) ev <= 8'h00;
    rd_reg(8'h39, 8'h81);
    wr_reg(8'h3a, 8'h7f);
    rd_reg(8'h3a, 8'h7f);
    @(posedge clk) #1 chk({7'h00, irq}, 8'h01);
    wr_reg(8'h39, 8'h81);
    @(posedge clk) #1 chk({7'h00, irq}, 8'h00);
  endtask : t_first
  task automatic complete_run;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // run is about 38 cycles; the limit leaves ample margin
  initial begin
    #20000 fails++;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset;
    t_pins;
    t_first;
    complete_run;
  end
endmodule : event_flag_mask_bank_tb
